// [pkg/alarm_cfg_pkg.sv]
// constants shared by the alarm configuration and flag block
package alarm_cfg_pkg;
    localparam int          ALARM_COUNT        = 3;
    localparam int          COUNT_WIDTH        = 32;
    // printed offsets are not all multiples of four, so they are indices
    localparam logic [3:0]  IDX_ALARM_CFG      = 4'h7;
    localparam logic [3:0]  IDX_IRQ_STATUS     = 4'h8;
    localparam logic [3:0]  IDX_IRQ_MASK       = 4'h9;
    localparam logic [3:0]  IDX_ALARM_VALUE0   = 4'hA;
    localparam logic [3:0]  IDX_COUNTER        = 4'hD;
    localparam int          ADDR_LSB           = 2;
    localparam int          ADDR_MSB           = 5;
    localparam int          BIT_ALARM2_FLAG    = 6;
    localparam int          BIT_ALARM1_FLAG    = 5;
    localparam int          BIT_ALARM0_FLAG    = 4;
    localparam int          BIT_CLEAR_ON_A0    = 3;
    localparam int          BIT_ALARM2_ENABLE  = 2;
    localparam int          BIT_ALARM1_ENABLE  = 1;
    localparam int          BIT_ALARM0_ENABLE  = 0;
    localparam int          FLAG_LSB           = BIT_ALARM0_FLAG;
    localparam logic [7:0]  ALARM_CFG_RESET    = 8'h00;
    localparam logic [2:0]  IRQ_RESET          = 3'h0;
    localparam logic [31:0] ALARM_VALUE_RESET  = 32'h0000_0000;
    localparam logic [31:0] COUNTER_RESET      = 32'h0000_0000;
    localparam logic [31:0] COUNTER_STEP       = 32'h0000_0001;
    // reserved bit 7 reads 0
    localparam logic [7:0]  ALARM_CFG_RW_MASK  = 8'h7F;
endpackage

// [rtl/alarm_comparator.sv]
// one alarm comparator: equality match gated by its enable
`timescale 1ns/10ps
`default_nettype none
module alarm_comparator
    import alarm_cfg_pkg::*;
(
    input  wire logic [COUNT_WIDTH-1:0] count,
    input  wire logic [COUNT_WIDTH-1:0] alarm_value,
    input  wire logic                   enable,
    output logic                        hit
);
    assign hit = enable && (count == alarm_value);
endmodule
`default_nettype wire

// [rtl/rtc_alarm_config_flags.sv]
// alarm configuration register, event flags, timer counter and wishbone slave
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_config_flags
    import alarm_cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        tick_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic             counter_cleared
);
    // architectural registers and their next values
    logic [7:0]             alarm_config_and_flags;
    logic [7:0]             next_alarm_config_and_flags;
    logic [2:0]             irq_status;
    logic [2:0]             next_irq_status;
    logic [2:0]             irq_mask;
    logic [2:0]             next_irq_mask;
    logic [COUNT_WIDTH-1:0] alarm_value [ALARM_COUNT];
    logic [COUNT_WIDTH-1:0] next_alarm_value [ALARM_COUNT];
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] next_count;
    logic                   next_counter_cleared;
    // bus answer and decode
    logic [31:0]            next_wb_dat_o;
    logic                   next_wb_ack_o;
    logic [2:0]             hit;
    logic [2:0]             enables;
    logic                   access;
    logic                   wr;
    logic                   rd;
    logic [3:0]             idx;
    logic [31:0]            wmask;
    // one strobe per register except the counter, plus the auto clear condition and the written config value
    logic                   cfg_wr;
    logic                   mask_wr;
    logic                   status_rd;
    logic [2:0]             value_wr;
    logic                   auto_clear;
    logic [7:0]             cfg_written;

    assign enables = alarm_config_and_flags[BIT_ALARM2_ENABLE:BIT_ALARM0_ENABLE];

    // one comparator per alarm, all watching the same count
    for (genvar g = 0; g < ALARM_COUNT; g++) begin : g_cmp
        alarm_comparator u_cmp (
            .count       (count),
            .alarm_value (alarm_value[g]),
            .enable      (enables[g]),
            .hit         (hit[g])
        );
    end

    // ack only in the cycle after the strobe, dropping between transfers
    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr        = access && wb_we_i;
    assign rd        = access && !wb_we_i;
    assign idx       = wb_adr_i[ADDR_MSB:ADDR_LSB];
    assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // the 8-bit config and 3-bit mask registers live in byte lane 0, other lanes leave them alone
    assign cfg_wr    = wr && wb_sel_i[0] && (idx == IDX_ALARM_CFG);
    assign mask_wr   = wr && wb_sel_i[0] && (idx == IDX_IRQ_MASK);
    assign status_rd = rd && (idx == IDX_IRQ_STATUS);

    for (genvar v = 0; v < ALARM_COUNT; v++) begin : g_value_sel
        assign value_wr[v] = wr && (idx == IDX_ALARM_VALUE0 + 4'(v));
    end

    // level interrupt straight from registers, no extra latency
    assign irq = |(irq_status & irq_mask);

    // auto clear only looks at alarm 0; the other alarms just raise flags
    assign auto_clear = hit[0] && alarm_config_and_flags[BIT_CLEAR_ON_A0];

    // control bits take the write, flags can only be cleared by a written 0
    always_comb begin
        cfg_written = alarm_config_and_flags;
        if (cfg_wr) begin
            cfg_written[BIT_CLEAR_ON_A0:BIT_ALARM0_ENABLE] = wb_dat_i[BIT_CLEAR_ON_A0:BIT_ALARM0_ENABLE];
            cfg_written[BIT_ALARM2_FLAG:FLAG_LSB] =
                alarm_config_and_flags[BIT_ALARM2_FLAG:FLAG_LSB] & wb_dat_i[BIT_ALARM2_FLAG:FLAG_LSB];
        end
        next_alarm_config_and_flags = cfg_written;
        // set wins over a same-cycle clear
        next_alarm_config_and_flags[BIT_ALARM2_FLAG] = cfg_written[BIT_ALARM2_FLAG] | hit[2];
        next_alarm_config_and_flags[BIT_ALARM1_FLAG] = cfg_written[BIT_ALARM1_FLAG] | hit[1];
        next_alarm_config_and_flags[BIT_ALARM0_FLAG] = cfg_written[BIT_ALARM0_FLAG] | hit[0];
        // reserved bit 7 never holds a one
        next_alarm_config_and_flags = next_alarm_config_and_flags & ALARM_CFG_RW_MASK;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_config_and_flags <= ALARM_CFG_RESET;
        end else begin
            alarm_config_and_flags <= next_alarm_config_and_flags;
        end
    end

    // status is sticky per alarm and cleared by reading it; an event in the
    // reading cycle survives so that no alarm is ever lost
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (status_rd) begin
            next_irq_status = IRQ_RESET;
        end
        next_irq_status = next_irq_status | hit;
        if (mask_wr) begin
            next_irq_mask = wb_dat_i[ALARM_COUNT-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= IRQ_RESET;
            irq_mask   <= IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // alarm values follow the byte lanes, so software may update one byte at a time
    always_comb begin
        next_alarm_value = alarm_value;
        for (int i = 0; i < ALARM_COUNT; i++) begin
            if (value_wr[i]) begin
                next_alarm_value[i] = (alarm_value[i] & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_value <= '{default: ALARM_VALUE_RESET};
        end else begin
            alarm_value <= next_alarm_value;
        end
    end

    // auto clear beats a tick in the same cycle, so the count restarts at zero
    // limitation: a count parked on a match re-sets the flag every cycle
    always_comb begin
        next_count           = count;
        next_counter_cleared = 1'b0;
        if (auto_clear) begin
            next_count           = COUNTER_RESET;
            next_counter_cleared = 1'b1;
        end else if (tick_en) begin
            next_count = count + COUNTER_STEP;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count           <= COUNTER_RESET;
            counter_cleared <= 1'b0;
        end else begin
            count           <= next_count;
            counter_cleared <= next_counter_cleared;
        end
    end

    // read data is zero outside an ack, so a stale value never shows on the bus
    // unmapped indices still ack and read zero; their writes are dropped
    // the counter index is read-only, a write there changes nothing
    always_comb begin
        next_wb_ack_o = access;
        next_wb_dat_o = 32'h0000_0000;
        if (rd) begin
            unique case (idx)
                IDX_ALARM_CFG: begin
                    next_wb_dat_o = {24'h00_0000, alarm_config_and_flags & ALARM_CFG_RW_MASK};
                end
                IDX_IRQ_STATUS: begin
                    next_wb_dat_o = {29'h000_0000, irq_status};
                end
                IDX_IRQ_MASK: begin
                    next_wb_dat_o = {29'h000_0000, irq_mask};
                end
                IDX_COUNTER: begin
                    next_wb_dat_o = count;
                end
                default: begin
                    for (int i = 0; i < ALARM_COUNT; i++) begin
                        if (idx == IDX_ALARM_VALUE0 + 4'(i)) begin
                            next_wb_dat_o = alarm_value[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            wb_dat_o <= next_wb_dat_o;
            wb_ack_o <= next_wb_ack_o;
        end
    end
endmodule
`default_nettype wire

// [sim/rtc_alarm_config_flags_properties.sv]
// bus timing, read data and post-reset irq checker for the alarm block
`timescale 1ns/10ps
`default_nettype none
module alarm_flags_checker (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    // bit 7 is reserved and must never leak out
    property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h7 |-> wb_dat_o[31:7] == 25'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("config upper bits set");
    property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i[5:2] > 4'hD |-> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_rst; $rose(rst_b) |-> !irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule
bind rtc_alarm_config_flags alarm_flags_checker u_chk (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq);
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the alarm configuration and flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb
    import alarm_cfg_pkg::*;
();
    logic        core_clk = 1'b0, rst_b = 1'b0, tick_en = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, seen_clr = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, q, r;
    logic [3:0]  sel = 4'hF;
    logic        ack, irq, clr;
    int          miscompares = 0, checks_done = 0, seed = 32'h4C72;
    rtc_alarm_config_flags u_dut (.core_clk, .rst_b, .tick_en, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq, .counter_cleared(clr));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (clr === 1'b1) seen_clr <= 1'b1;
    // flags only survive a write of 1, control bits take the written value
    function automatic logic [31:0] after_wr(logic [7:0] old, logic [7:0] w);
        return {24'h0, 1'b0, old[6:4] & w[6:4], w[3:0]};
    endfunction
    task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d, input logic [3:0] s = 4'hF);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, 26'h0, i, 2'h0, d, s};
        @(posedge core_clk iff ack === 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] i, input logic [31:0] e);
        wb(1'b0, i, 32'h0);
        `CHK(q, e)
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            tick_en <= 1'b1;
            @(posedge core_clk);
            tick_en <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // whole sequence is well under a thousand cycles
    initial begin
        #20us;
        miscompares++;
        results;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(IDX_ALARM_CFG, 32'h0);
        rd(IDX_IRQ_STATUS, 32'h0);
        for (int k = 0; k < 3; k++) wb(1'b1, 4'(IDX_ALARM_VALUE0 + k), 32'h5 + k);
        wb(1'b1, IDX_ALARM_CFG, 32'h07);
        rd(IDX_ALARM_CFG, 32'h07);
        tk(5);
        rd(IDX_ALARM_CFG, 32'h17);
        tk(1);
        rd(IDX_ALARM_CFG, 32'h37);
        tk(1);
        rd(IDX_ALARM_CFG, 32'h77);
        tk(1);
        rd(IDX_COUNTER, 32'h8);
        `CHK(seen_clr, 1'b0)
        `CHK(irq, 1'b0)
        wb(1'b1, IDX_ALARM_CFG, 32'h77);
        rd(IDX_ALARM_CFG, after_wr(8'h77, 8'h77));
        wb(1'b1, IDX_ALARM_CFG, 32'h07);
        rd(IDX_ALARM_CFG, after_wr(8'h77, 8'h07));
        wb(1'b1, IDX_IRQ_MASK, 32'h7);
        `CHK(irq, 1'b1)
        rd(IDX_IRQ_STATUS, 32'h7);
        `CHK(irq, 1'b0)
        rd(IDX_IRQ_STATUS, 32'h0);
        repeat (4) begin
            r = $random(seed);
            wb(1'b1, IDX_IRQ_MASK, r);
            rd(IDX_IRQ_MASK, r & 32'h7);
            wb(1'b1, 4'(r[3:0] % 7), r);
        end
        rd(IDX_ALARM_CFG, 32'h07);
        wb(1'b1, IDX_ALARM_VALUE0, 32'hA);
        wb(1'b1, IDX_ALARM_CFG, 32'h09);
        tk(2);
        rd(IDX_COUNTER, 32'h0);
        `CHK(seen_clr, 1'b1)
        rd(IDX_ALARM_CFG, 32'h19);
        wb(1'b1, IDX_ALARM_CFG, 32'h01);
        tk(10);
        rd(IDX_COUNTER, 32'hA);
        rd(IDX_ALARM_CFG, 32'h11);
        wb(1'b1, IDX_ALARM_CFG, 32'h0, 4'hE);
        rd(IDX_ALARM_CFG, 32'h11);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(IDX_ALARM_CFG, 32'h0);
        rd(IDX_COUNTER, 32'h0);
        `CHK(irq, 1'b0)
        rd(4'hF, 32'h0);
        results;
    end
endmodule
`default_nettype wire
